// ===== design/rwg_top.sv
/*
 * Register write guard: an AHB-Lite slave holding the unlock bits, the
 * guarded configuration registers and the battery backup store.
 * Assumes one AHB-Lite master, single word transfers, hreadyout used as
 * hready, and that only the block's low 12 address bits are decoded.
 */
// Notes on behaviour
// - Clock registers writable only while clock unlocked.
// - Oscillator frequency register sits in clock group.
// - Low-power registers writable only while power unlocked.
// - Battery backup registers and store need power unlock.
// - Voltage detector registers need voltage-detect unlock.
// - Security attribute registers need security unlock.
// - Both reset mask registers need reset-mask unlock.
// - Reset-mask unlock exists only in secure view.
`timescale 1ns/1ps
`include "rwg_params.svh"

module rwg_top import rwg_pkg::*; #(
    parameter int BKP_WORDS = `RWG_BKP_WORDS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output rwg_unlock_t unlock_state,
    output rwg_cfg_t cfg
);

    // ------------------------------------------------------------------------
    // Constants of the guarded register set.
    // ------------------------------------------------------------------------
    localparam int GN = `RWG_GUARDED_REGS;
    localparam int IDXW = $clog2(BKP_WORDS);
    // Offsets of the guarded registers, in cfg order.
    localparam logic [11:0] G_OFF [GN] = '{`RWG_OFF_CLK_DIV, `RWG_OFF_OSC_FREQ,
        `RWG_OFF_PWR_CTRL, `RWG_OFF_VDET_CTRL, `RWG_OFF_SEC_ATTR,
        `RWG_OFF_RSTMSK_A, `RWG_OFF_RSTMSK_B};
    // Unlock bit that opens each guarded register.
    localparam int G_BIT [GN] = '{`RWG_BIT_CLK, `RWG_BIT_CLK, `RWG_BIT_PWR,
        `RWG_BIT_VDET, `RWG_BIT_SEC, `RWG_BIT_RST, `RWG_BIT_RST};

    // ------------------------------------------------------------------------
    // State and next values.
    // ------------------------------------------------------------------------
    logic dp_valid_reg, dp_valid_next; // A data phase is in progress.
    logic dp_write_reg, dp_write_next; // That data phase is a write.
    logic [11:0] dp_addr_reg, dp_addr_next; // Its decoded address.
    rwg_unlock_t unlock_reg, unlock_next; // Unlock bits.
    logic [15:0] rej_reg, rej_next; // Saturating count of refused writes.
    logic [31:0] rdata_reg, rdata_next; // Read data for the next data phase.
    logic ready_reg; // Ready flop; the block never inserts waits.
    logic resp_reg; // Response flop; every transfer answers OKAY.
    logic [31:0] bkp_mem [BKP_WORDS]; // Battery backup store.
    logic ap_take; // An address phase is accepted this cycle.
    logic wr_go; // Write data is on hwdata this cycle.
    logic [5:0] unlock_vec; // Unlock bits at their register positions.
    logic [GN-1:0] wr_hit; // Write strobe per guarded register.
    logic [GN-1:0] g_open; // Unlock state per guarded register.
    logic [31:0] gq [GN]; // Guarded register values.
    logic [31:0] gn [GN]; // Guarded register next values.
    logic bkp_hit; // Data phase write targets the backup store.
    logic bkp_wr; // That write is permitted.
    logic [IDXW-1:0] dp_idx; // Backup word written this cycle.
    logic [IDXW-1:0] ap_idx; // Backup word addressed for a read.
    logic [31:0] bkp_cur; // Present content of the written word.
    logic refused; // A guarded write is being dropped.

    assign ap_take = hsel && htrans[1] && hready;
    assign wr_go = dp_valid_reg && dp_write_reg;
    assign unlock_vec = {unlock_reg.rst, unlock_reg.sec, unlock_reg.vdet, 1'b0,
        unlock_reg.pwr, unlock_reg.clk};
    assign dp_idx = dp_addr_reg[IDXW+1:2];
    assign ap_idx = haddr[IDXW+1:2];
    assign bkp_hit = wr_go && (dp_addr_reg[11:9] == `RWG_BKP_BASE_HI);
    assign bkp_wr = bkp_hit && unlock_reg.pwr;
    assign bkp_cur = bkp_mem[dp_idx];

    // ------------------------------------------------------------------------
    // Guarded registers, one instance each.
    // ------------------------------------------------------------------------
    for (genvar g = 0; g < GN; g++) begin : g_guard
        assign wr_hit[g] = wr_go && (dp_addr_reg == G_OFF[g]);
        assign g_open[g] = unlock_vec[G_BIT[g]];
        rwg_guarded_reg #(.WIDTH(32), .RESET_VAL(`RWG_RST_WORD)) u_reg (
            .hclk(hclk),
            .hresetn(hresetn),
            .wr_hit(wr_hit[g]),
            .unlock(g_open[g]),
            .wdata(hwdata),
            .q(gq[g]),
            .q_next(gn[g])
        );
    end

    assign refused = (|(wr_hit & ~g_open)) || (bkp_hit && !unlock_reg.pwr);

    // ------------------------------------------------------------------------
    // Bus, unlock and read data next values.
    // ------------------------------------------------------------------------
    always_comb begin
        dp_valid_next = ap_take;
        dp_write_next = ap_take && hwrite;
        dp_addr_next = ap_take ? haddr[11:0] : dp_addr_reg;
        unlock_next = unlock_reg;
        // Secure view writes every unlock bit.
        if (wr_go && dp_addr_reg == `RWG_OFF_SEC_PROT) begin
            unlock_next.clk = hwdata[`RWG_BIT_CLK];
            unlock_next.pwr = hwdata[`RWG_BIT_PWR];
            unlock_next.vdet = hwdata[`RWG_BIT_VDET];
            unlock_next.sec = hwdata[`RWG_BIT_SEC];
            unlock_next.rst = hwdata[`RWG_BIT_RST];
        end else if (wr_go && dp_addr_reg == `RWG_OFF_NS_PROT) begin
            // Non-secure view has no reset-mask bit; it is left alone.
            unlock_next.clk = hwdata[`RWG_BIT_CLK];
            unlock_next.pwr = hwdata[`RWG_BIT_PWR];
            unlock_next.vdet = hwdata[`RWG_BIT_VDET];
            unlock_next.sec = hwdata[`RWG_BIT_SEC];
        end
        // Count dropped writes, holding at the top value.
        rej_next = rej_reg;
        if (refused && rej_reg != 16'hFFFF) begin
            rej_next = rej_reg + 16'h0001;
        end
        // Reads see next values so a write just before is never stale.
        rdata_next = 32'h0000_0000;
        if (ap_take && !hwrite) begin
            if (haddr[11:9] == `RWG_BKP_BASE_HI) begin
                rdata_next = (bkp_wr && dp_idx == ap_idx) ? hwdata : bkp_mem[ap_idx];
            end else begin
                case (haddr[11:0])
                    `RWG_OFF_SEC_PROT: rdata_next = {26'h0, unlock_next.rst,
                        unlock_next.sec, unlock_next.vdet, 1'b0, unlock_next.pwr,
                        unlock_next.clk};
                    // Reset-mask bit reads zero through the non-secure view.
                    `RWG_OFF_NS_PROT: rdata_next = {27'h0, unlock_next.sec,
                        unlock_next.vdet, 1'b0, unlock_next.pwr, unlock_next.clk};
                    `RWG_OFF_REJ_CNT: rdata_next = {16'h0, rej_next};
                    default: begin
                        for (int i = 0; i < GN; i++) begin
                            if (haddr[11:0] == G_OFF[i]) begin
                                rdata_next = gn[i];
                            end
                        end
                    end
                endcase
            end
        end else begin
            rdata_next = rdata_reg;
        end
    end

    // Registers the bus state; all unlock bits clear on reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg <= 12'h000;
            unlock_reg <= '0;
            rej_reg <= `RWG_RST_CNT;
            rdata_reg <= `RWG_RST_WORD;
            ready_reg <= 1'b1;
            resp_reg <= 1'b0;
        end else begin
            dp_valid_reg <= dp_valid_next;
            dp_write_reg <= dp_write_next;
            dp_addr_reg <= dp_addr_next;
            unlock_reg <= unlock_next;
            rej_reg <= rej_next;
            rdata_reg <= rdata_next;
            ready_reg <= 1'b1;
            resp_reg <= 1'b0;
        end
    end

    // Backup store; cleared at reset so reads are never unknown.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < BKP_WORDS; i++) begin
                bkp_mem[i] <= `RWG_RST_WORD;
            end
        end else if (bkp_wr) begin
            bkp_mem[dp_idx] <= hwdata;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------------
    assign hreadyout = ready_reg;
    assign hresp = resp_reg;
    assign hrdata = rdata_reg;
    assign unlock_state = unlock_reg;
    assign cfg = '{rstmsk_b: gq[6], rstmsk_a: gq[5], sec_attr: gq[4],
        vdet_ctrl: gq[3], pwr_ctrl: gq[2], osc_freq: gq[1], clk_div: gq[0]};

    // ------------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_clk_lock;
        wr_go && dp_addr_reg == `RWG_OFF_CLK_DIV && !unlock_reg.clk |=> $stable(cfg.clk_div);
    endproperty
    a_clk_lock: assert property (p_clk_lock)
        else $error("Clock divider changed while clock group locked.");

    property p_osc_open;
        wr_go && dp_addr_reg == `RWG_OFF_OSC_FREQ && unlock_reg.clk
            |=> cfg.osc_freq == $past(hwdata);
    endproperty
    a_osc_open: assert property (p_osc_open)
        else $error("Oscillator frequency not written under clock unlock.");

    property p_pwr_lock;
        wr_go && dp_addr_reg == `RWG_OFF_PWR_CTRL && !unlock_reg.pwr |=> $stable(cfg.pwr_ctrl);
    endproperty
    a_pwr_lock: assert property (p_pwr_lock)
        else $error("Power control changed while power group locked.");

    property p_bkp_lock;
        bkp_hit && !unlock_reg.pwr |=> bkp_mem[$past(dp_idx)] == $past(bkp_cur);
    endproperty
    a_bkp_lock: assert property (p_bkp_lock)
        else $error("Backup store changed while power group locked.");

    property p_vdet_lock;
        wr_go && dp_addr_reg == `RWG_OFF_VDET_CTRL && !unlock_reg.vdet
            |=> $stable(cfg.vdet_ctrl);
    endproperty
    a_vdet_lock: assert property (p_vdet_lock)
        else $error("Voltage detector changed while locked.");

    property p_sec_lock;
        wr_go && dp_addr_reg == `RWG_OFF_SEC_ATTR && !unlock_reg.sec |=> $stable(cfg.sec_attr);
    endproperty
    a_sec_lock: assert property (p_sec_lock)
        else $error("Security attribute changed while locked.");

    property p_rst_lock;
        wr_go && dp_addr_reg[11:4] == 8'h02 && !unlock_reg.rst
            |=> $stable(cfg.rstmsk_a) && $stable(cfg.rstmsk_b);
    endproperty
    a_rst_lock: assert property (p_rst_lock)
        else $error("Reset mask changed while locked.");

    property p_ns_no_rst;
        wr_go && dp_addr_reg == `RWG_OFF_NS_PROT |=> unlock_state.rst == $past(unlock_reg.rst);
    endproperty
    a_ns_no_rst: assert property (p_ns_no_rst)
        else $error("Non-secure view altered reset-mask unlock.");

    property p_ns_read;
        ap_take && !hwrite && haddr[11:0] == `RWG_OFF_NS_PROT |=> hrdata[`RWG_BIT_RST] == 1'b0;
    endproperty
    a_ns_read: assert property (p_ns_read)
        else $error("Non-secure view showed reset-mask unlock.");

    c_unlock_both: cover property (unlock_reg.clk && unlock_reg.pwr);
    c_refused: cover property (refused);
    c_bkp_write: cover property (bkp_wr);
    c_rst_open: cover property (wr_hit[5] && g_open[5]);

endmodule // rwg_top

// ===== design/rwg_params.svh
/*
 * Constants of the register write guard: register offsets, unlock bit
 * positions, reset values and address decode figures.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef RWG_PARAMS_SVH
`define RWG_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses within the block's 4 KiB window).
// ----------------------------------------------------------------------------
`define RWG_OFF_SEC_PROT 12'h000
`define RWG_OFF_NS_PROT 12'h004
`define RWG_OFF_CLK_DIV 12'h010
`define RWG_OFF_OSC_FREQ 12'h014
`define RWG_OFF_PWR_CTRL 12'h018
`define RWG_OFF_VDET_CTRL 12'h01C
`define RWG_OFF_SEC_ATTR 12'h020
`define RWG_OFF_RSTMSK_A 12'h024
`define RWG_OFF_RSTMSK_B 12'h028
`define RWG_OFF_REJ_CNT 12'h030
`define RWG_BKP_BASE_HI 3'h1

// ----------------------------------------------------------------------------
// Unlock bit positions inside the protect control registers.
// ----------------------------------------------------------------------------
`define RWG_BIT_CLK 0
`define RWG_BIT_PWR 1
`define RWG_BIT_VDET 3
`define RWG_BIT_SEC 4
`define RWG_BIT_RST 5

// ----------------------------------------------------------------------------
// Reset values and sizes.
// ----------------------------------------------------------------------------
`define RWG_RST_WORD 32'h0000_0000
`define RWG_RST_CNT 16'h0000
`define RWG_BKP_WORDS 128
`define RWG_GUARDED_REGS 7

`endif

// ===== design/rwg_pkg.sv
/*
 * Types shared by the register write guard modules.
 * Assumes rwg_params.svh is on the include path.
 */
`include "rwg_params.svh"

package rwg_pkg;

    // ------------------------------------------------------------------------
    // Unlock bits, one per protected register group.
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic rst;  // Reset mask group, secure view only.
        logic sec;  // Security and privilege attribute group.
        logic vdet; // Voltage detector group.
        logic pwr;  // Low-power and battery backup group.
        logic clk;  // Clock generation group.
    } rwg_unlock_t;

    // ------------------------------------------------------------------------
    // Contents of the guarded configuration registers.
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] rstmsk_b;
        logic [31:0] rstmsk_a;
        logic [31:0] sec_attr;
        logic [31:0] vdet_ctrl;
        logic [31:0] pwr_ctrl;
        logic [31:0] osc_freq;
        logic [31:0] clk_div;
    } rwg_cfg_t;

endpackage

// ===== design/rwg_guarded_reg.sv
/*
 * One guarded configuration register: it takes a write only while its
 * group's unlock bit is set.
 * Assumes wr_hit is a one-cycle write strobe with wdata valid beside it.
 */
`timescale 1ns/1ps
`include "rwg_params.svh"

module rwg_guarded_reg #(
    parameter int WIDTH = 32,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic wr_hit,
    input wire logic unlock,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] q,
    output logic [WIDTH-1:0] q_next
);

    // ------------------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------------------
    logic [WIDTH-1:0] val_reg; // Held register value.
    logic [WIDTH-1:0] val_next; // Value after this cycle.

    // A locked write leaves the contents untouched.
    always_comb begin
        val_next = val_reg;
        if (wr_hit && unlock) begin
            val_next = wdata;
        end
    end

    // Registers the value; reset restores the documented default.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            val_reg <= RESET_VAL;
        end else begin
            val_reg <= val_next;
        end
    end

    assign q = val_reg;
    assign q_next = val_next;

    // ------------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------------
    property p_locked_hold;
        @(posedge hclk) disable iff (!hresetn)
        wr_hit && !unlock |=> $stable(val_reg);
    endproperty
    a_locked_hold: assert property (p_locked_hold)
        else $error("Locked write changed a guarded register.");

    property p_open_take;
        @(posedge hclk) disable iff (!hresetn)
        wr_hit && unlock |=> val_reg == $past(wdata);
    endproperty
    a_open_take: assert property (p_open_take)
        else $error("Unlocked write did not land in a guarded register.");

endmodule // rwg_guarded_reg

// ===== tb/rwg_tb.sv
/*
 * Self-checking bench for the register write guard, driving its AHB-Lite port.
 * Assumes the design package and modules are compiled first, with hready
 * looped back from hreadyout as the only slave on the bus.
 */
`timescale 1ns/1ps
`include "rwg_params.svh"

module tb import rwg_pkg::*; ;

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    // One table row: protect word, then a write and its expected readback.
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] prot;
        logic [31:0] data;
        logic [31:0] exp;
    } rwg_row_t;

    // Each register first while its own bit is clear, then while only it is set.
    localparam rwg_row_t ROWS [18] = '{
        '{12'h010, 8'h3A, 32'hDEAD_0010, 32'h0000_0000},
        '{12'h010, 8'h01, 32'h1234_5610, 32'h1234_5610},
        '{12'h014, 8'h3A, 32'hDEAD_0014, 32'h0000_0000},
        '{12'h014, 8'h01, 32'h1234_5614, 32'h1234_5614},
        '{12'h018, 8'h39, 32'hDEAD_0018, 32'h0000_0000},
        '{12'h018, 8'h02, 32'h1234_5618, 32'h1234_5618},
        '{12'h01C, 8'h33, 32'hDEAD_001C, 32'h0000_0000},
        '{12'h01C, 8'h08, 32'h1234_561C, 32'h1234_561C},
        '{12'h020, 8'h2B, 32'hDEAD_0020, 32'h0000_0000},
        '{12'h020, 8'h10, 32'h1234_5620, 32'h1234_5620},
        '{12'h024, 8'h1B, 32'hDEAD_0024, 32'h0000_0000},
        '{12'h024, 8'h20, 32'h1234_5624, 32'h1234_5624},
        '{12'h028, 8'h1B, 32'hDEAD_0028, 32'h0000_0000},
        '{12'h028, 8'h20, 32'h1234_5628, 32'h1234_5628},
        '{12'h200, 8'h39, 32'hDEAD_0200, 32'h0000_0000},
        '{12'h200, 8'h02, 32'h1234_5700, 32'h1234_5700},
        '{12'h3FC, 8'h39, 32'hDEAD_03FC, 32'h0000_0000},
        '{12'h3FC, 8'h02, 32'h1234_57FC, 32'h1234_57FC}
    };

    logic hclk; // Bus clock, 4 ns period.
    logic hresetn; // Asynchronous reset, active low.
    logic hsel; // Slave select.
    logic [31:0] haddr; // Byte address.
    logic [1:0] htrans; // Transfer type.
    logic hwrite; // Write when high.
    logic [2:0] hsize; // Always a word.
    logic [31:0] hwdata; // Write data.
    logic hready; // Bus ready, looped back.
    logic hreadyout; // Slave ready.
    logic hresp; // Slave response.
    logic [31:0] hrdata; // Read data.
    rwg_unlock_t unlock_state; // Unlock bits seen at the port.
    rwg_cfg_t cfg; // Guarded register contents.
    int bad_count; // Mismatches seen.
    int compares; // Comparisons made.
    int exp_cnt; // Expected refused-write count.
    logic [31:0] q; // Last read word.

    assign hready = hreadyout;

    rwg_top i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .unlock_state(unlock_state), .cfg(cfg)
    );

    // The clock toggles every half period.
    always #2 hclk = ~hclk;

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    // Compares a seen value with the expected one and counts both outcomes.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One single AHB-Lite transfer; the read word is taken at the data edge.
    // It waits on hready for as long as it takes; only the watchdog ends a hang.
    task automatic bus(input logic wr_en, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd_q);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr_en;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            @(posedge hclk);
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            @(posedge hclk);
        end
        rd_q = hrdata;
    endtask

    // Write then read back one word and compare it.
    task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    // Prints the verdict and stops the run.
    task automatic end_sim;
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short well past the expected run length.
    initial begin
        #20000;
        bad_count++;
        end_sim();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        bad_count = 0;
        compares = 0;
        exp_cnt = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Everything starts locked and cleared.
        chk({27'h0, unlock_state}, 32'h0);
        chk(cfg[31:0], 32'h0);
        chk({30'h0, hreadyout, hresp}, 32'h2);
        // The non-secure view never sets or shows the reset-mask bit.
        wr_rd(12'h004, 32'h0000_003B, 32'h0000_001B);
        wr_rd(12'h000, 32'h0000_0020, 32'h0000_0020);
        bus(1'b0, 12'h004, 32'h0, q);
        chk(q, 32'h0);
        wr_rd(12'h004, 32'h0000_0000, 32'h0000_0000);
        bus(1'b0, 12'h000, 32'h0, q);
        chk(q, 32'h0000_0020);
        // Table of guarded writes, locked by the wrong bits then unlocked.
        for (int i = 0; i < 18; i++) begin
            wr_rd(12'h000, {24'h0, ROWS[i].prot}, {24'h0, ROWS[i].prot});
            chk({27'h0, unlock_state}, {27'h0, ROWS[i].prot[5:3], ROWS[i].prot[1:0]});
            if (ROWS[i].exp !== ROWS[i].data) begin
                exp_cnt++;
            end
            wr_rd(ROWS[i].addr, ROWS[i].data, ROWS[i].exp);
            if (ROWS[i].addr < 12'h030) begin
                chk(cfg[32 * ((ROWS[i].addr - 12'h010) >> 2) +: 32], ROWS[i].exp);
            end
        end
        // The refused counter is read only and ignores unmapped places.
        wr_rd(`RWG_OFF_REJ_CNT, 32'h0000_0055, exp_cnt);
        wr_rd(12'h100, 32'h0000_00AA, 32'h0);
        // Oscillator setup: unlock clock and power, configure, relock.
        wr_rd(12'h000, 32'h0000_0003, 32'h0000_0003);
        wr_rd(12'h014, 32'h0000_0005, 32'h0000_0005);
        wr_rd(12'h018, 32'h0000_0077, 32'h0000_0077);
        wr_rd(12'h000, 32'h0000_0000, 32'h0000_0000);
        wr_rd(12'h014, 32'hFFFF_FFFF, 32'h0000_0005);
        wr_rd(12'h018, 32'hFFFF_FFFF, 32'h0000_0077);
        chk(cfg.osc_freq, 32'h0000_0005);
        bus(1'b0, `RWG_OFF_REJ_CNT, 32'h0, q);
        chk(q, exp_cnt + 2);
        // A reset in mid-run clears unlock bits and guarded contents.
        wr_rd(12'h000, 32'h0000_003B, 32'h0000_003B);
        hresetn <= 1'b0;
        @(negedge hclk);
        chk({27'h0, unlock_state}, 32'h0);
        chk(cfg[63:32], 32'h0);
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        wr_rd(12'h3FC, 32'h0000_1111, 32'h0);
        end_sim();
    end

endmodule // tb
